/* File: pmbo_pkg.sv */
// constants of the power monitor and brown-out block
// assumes a 32-bit APB register port and a single 125 MHz clock
package pmbo_pkg;

    // bus geometry
    localparam int unsigned PMBO_ADDR_W = 12;
    localparam int unsigned PMBO_DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [9:0] PMBO_IDX_PWR_CTRL = 10'h087;
    localparam logic [9:0] PMBO_IDX_MON_CTRL = 10'h0A3;
    localparam logic [9:0] PMBO_IDX_TA_KEY = 10'h0A4;
    localparam logic [9:0] PMBO_IDX_CFG_BYTE = 10'h0A5;

    // monitor control field positions
    localparam int unsigned PMBO_BIT_DET_EN = 7;
    localparam int unsigned PMBO_BIT_THR_SEL = 6;
    localparam int unsigned PMBO_BIT_RST_SEL = 4;
    localparam int unsigned PMBO_BIT_EVT_FLAG = 3;
    localparam int unsigned PMBO_BIT_STATUS = 0;
    // power control field position
    localparam int unsigned PMBO_BIT_COLD = 4;
    // configuration byte field positions
    localparam int unsigned PMBO_CFG_DET_DIS = 7;
    localparam int unsigned PMBO_CFG_THR = 6;
    localparam int unsigned PMBO_CFG_RST_SEL = 4;

    // unprogrammed configuration byte
    localparam logic [7:0] PMBO_CFG_RESET = 8'hFF;
    // control bits as they stand before the first load
    localparam logic PMBO_DET_EN_RESET = 1'h0;
    localparam logic PMBO_THR_SEL_RESET = 1'h0;
    localparam logic PMBO_RST_SEL_RESET = 1'h1;

    // timed access key bytes
    localparam logic [7:0] PMBO_TA_KEY1 = 8'hAA;
    localparam logic [7:0] PMBO_TA_KEY2 = 8'h55;

    // timing
    localparam int unsigned PMBO_CLK_PERIOD_NS = 8;
    localparam int unsigned PMBO_TA_WINDOW_NS = 64;
    localparam int unsigned PMBO_TA_WINDOW_CYC =
        (PMBO_TA_WINDOW_NS / PMBO_CLK_PERIOD_NS < 1) ? 1 :
        PMBO_TA_WINDOW_NS / PMBO_CLK_PERIOD_NS;

    // timed access sequencer states
    typedef enum logic [1:0] {
        TA_IDLE,
        TA_HALF,
        TA_OPEN
    } pmbo_ta_e;

endpackage : pmbo_pkg

/* File: pmbo_sync.sv */
// two-flop synchroniser for asynchronous level inputs
// assumes inputs are slow levels; only stage two may be read
`timescale 1ns/1ps
`default_nettype none
module pmbo_sync #(
    parameter int unsigned WIDTH = 2
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : pmbo_sync
`default_nettype wire

/* File: pmbo_top.sv */
// power-on flag, brown-out detection control and APB register file
// assumes comparator and power-on detector levels arrive asynchronously,
// warm reset and interrupt enables come from logic on pclk
//
// Function
// R1: power-on detection sets cold-reset flag
// R2: software clears cold flag; stays until power-on
// R3: drop with reset-select 0 sets flag, interrupt
// R4: drop with reset-select 1 resets the CPU
// R5: flag set only on crossings, not levels
// R6: flag set on falling and rising crossings; code sets it on a falling one only with reset-select 0
// R7: flag cleared by software only
// R8: irq when flag, irq enable, global enable
// R9: detection enable loads inverted config bit 7
// R10: detection runs only while enable is 1
// R11: threshold select 0 low, 1 high
// R12: threshold select loads inverted config bit
// R13: status bit 0 is 1 above threshold
// R14: software writes 0 to control bit 2
// R15: control writes need timed access unlock
// R16: software clears stale flag at initialisation
// R17: unprogrammed config byte reads all ones
// R18: cold flag kept across warm resets
// R19: comparator synchronised, edges make events
// R20: disabled detection suppresses flag, irq, reset
`timescale 1ns/1ps
`default_nettype none
module pmbo_top
    import pmbo_pkg::*;
(
    // clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PMBO_ADDR_W-1:0] paddr,
    input wire logic [PMBO_DATA_W-1:0] pwdata,
    output logic [PMBO_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog side
    input wire logic supply_below,
    input wire logic por_level_ok,
    output logic det_enable_out,
    output logic thr_select_out,
    // cpu, reset and interrupt side
    input wire logic warm_reset,
    input wire logic brownout_irq_enable,
    input wire logic global_irq_enable,
    output logic brownout_reset_req,
    output logic brownout_irq_req
);

    // synchronised analog levels
    logic [1:0] async_lv;
    logic [1:0] sync_lv;
    logic below_sync;
    logic por_sync;
    logic below_q_reg;
    logic por_q_reg;
    logic fall_xing;
    logic rise_xing;
    logic por_rise;

    // register state
    logic det_en_reg;
    logic thr_sel_reg;
    logic rst_sel_reg;
    logic evt_flag_reg;
    logic cold_flag_reg;
    logic [7:0] cfg_byte_reg;
    logic load_pend_reg;
    pmbo_ta_e ta_state_reg;
    logic [7:0] ta_cnt_reg;

    // bus decode
    logic [9:0] idx;
    logic hit;
    logic acc_start;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_ctrl_ok;
    logic wr_pwr;
    logic wr_ta;
    logic wr_cfg;
    logic cfg_load;
    logic [7:0] rd_byte;

    // R19 comparator synchroniser
    assign async_lv = {por_level_ok, supply_below};
    pmbo_sync #(
        .WIDTH(2)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(async_lv),
        .sync_out(sync_lv)
    );
    assign below_sync = sync_lv[0];
    assign por_sync = sync_lv[1];

    // delayed copies for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            below_q_reg <= 1'h0;
            por_q_reg <= 1'h0;
        end else begin
            below_q_reg <= below_sync;
            por_q_reg <= por_sync;
        end
    end

    // R19 crossings from synced edges
    assign fall_xing = below_sync & ~below_q_reg;
    assign rise_xing = ~below_sync & below_q_reg;
    assign por_rise = por_sync & ~por_q_reg;

    // bus decode and strobes
    assign idx = paddr[11:2];
    assign hit = (idx == PMBO_IDX_MON_CTRL) || (idx == PMBO_IDX_PWR_CTRL) ||
                 (idx == PMBO_IDX_TA_KEY) || (idx == PMBO_IDX_CFG_BYTE);
    assign acc_start = psel & penable & ~pready;
    assign wr_fire = psel & penable & pready & pwrite;
    assign wr_ctrl = wr_fire & (idx == PMBO_IDX_MON_CTRL);
    assign wr_pwr = wr_fire & (idx == PMBO_IDX_PWR_CTRL);
    assign wr_ta = wr_fire & (idx == PMBO_IDX_TA_KEY);
    assign wr_cfg = wr_fire & (idx == PMBO_IDX_CFG_BYTE);
    // R15 control write honoured only while unlocked
    assign wr_ctrl_ok = wr_ctrl & (ta_state_reg == TA_OPEN);
    assign cfg_load = load_pend_reg | warm_reset;

    // pending load after power-on release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_pend_reg <= 1'h1;
        end else begin
            load_pend_reg <= 1'h0;
        end
    end

    // R17 config byte, unprogrammed all ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_byte_reg <= PMBO_CFG_RESET;
        end else if (wr_cfg) begin
            cfg_byte_reg <= pwdata[7:0];
        end
    end

    // R15 timed access unlock sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ta_state_reg <= TA_IDLE;
            ta_cnt_reg <= 8'h00;
        end else begin
            case (ta_state_reg)
                TA_IDLE: begin
                    if (wr_ta && pwdata[7:0] == PMBO_TA_KEY1) begin
                        ta_state_reg <= TA_HALF;
                    end
                end
                TA_HALF: begin
                    if (wr_ta && pwdata[7:0] == PMBO_TA_KEY2) begin
                        ta_state_reg <= TA_OPEN;
                        ta_cnt_reg <= 8'(PMBO_TA_WINDOW_CYC);
                    end else if (wr_ta) begin
                        ta_state_reg <= TA_IDLE;
                    end
                end
                TA_OPEN: begin
                    // window closes on use or on timeout
                    if (wr_ctrl || ta_cnt_reg == 8'h01) begin
                        ta_state_reg <= TA_IDLE;
                        ta_cnt_reg <= 8'h00;
                    end else begin
                        ta_cnt_reg <= ta_cnt_reg - 8'h01;
                    end
                end
                default: begin
                    ta_state_reg <= TA_IDLE;
                end
            endcase
        end
    end

    // R9 R12 control bits load from config at every reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_en_reg <= PMBO_DET_EN_RESET;
            thr_sel_reg <= PMBO_THR_SEL_RESET;
            rst_sel_reg <= PMBO_RST_SEL_RESET;
        end else if (cfg_load) begin
            det_en_reg <= ~cfg_byte_reg[PMBO_CFG_DET_DIS];
            thr_sel_reg <= ~cfg_byte_reg[PMBO_CFG_THR];
            rst_sel_reg <= cfg_byte_reg[PMBO_CFG_RST_SEL];
        end else if (wr_ctrl_ok) begin
            det_en_reg <= pwdata[PMBO_BIT_DET_EN];
            thr_sel_reg <= pwdata[PMBO_BIT_THR_SEL];
            rst_sel_reg <= pwdata[PMBO_BIT_RST_SEL];
        end
    end

    // R3 R5 R6 R7 R20 sticky event flag, hardware set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_flag_reg <= 1'h0;
        end else if (det_en_reg && (rise_xing ||
                     (fall_xing && !rst_sel_reg))) begin
            evt_flag_reg <= 1'h1;
        end else if (wr_ctrl_ok) begin
            evt_flag_reg <= pwdata[PMBO_BIT_EVT_FLAG];
        end
    end

    // R1 R2 R18 cold flag; warm reset leaves it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cold_flag_reg <= 1'h0;
        end else if (por_rise) begin
            cold_flag_reg <= 1'h1;
        end else if (wr_pwr) begin
            cold_flag_reg <= pwdata[PMBO_BIT_COLD];
        end
    end

    // R4 R10 R20 reset request on a falling crossing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_reset_req <= 1'h0;
        end else begin
            brownout_reset_req <= det_en_reg & rst_sel_reg & fall_xing;
        end
    end

    // R8 R20 interrupt request gate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_irq_req <= 1'h0;
        end else begin
            brownout_irq_req <= evt_flag_reg & det_en_reg &
                                brownout_irq_enable & global_irq_enable;
        end
    end

    // R10 R11 analog controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_enable_out <= PMBO_DET_EN_RESET;
            thr_select_out <= PMBO_THR_SEL_RESET;
        end else begin
            det_enable_out <= det_en_reg;
            thr_select_out <= thr_sel_reg;
        end
    end

    // R13 read multiplexer, reserved bits zero
    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            PMBO_IDX_MON_CTRL: begin
                rd_byte[PMBO_BIT_DET_EN] = det_en_reg;
                rd_byte[PMBO_BIT_THR_SEL] = thr_sel_reg;
                rd_byte[PMBO_BIT_RST_SEL] = rst_sel_reg;
                rd_byte[PMBO_BIT_EVT_FLAG] = evt_flag_reg;
                rd_byte[PMBO_BIT_STATUS] = ~below_sync;
            end
            PMBO_IDX_PWR_CTRL: begin
                rd_byte[PMBO_BIT_COLD] = cold_flag_reg;
            end
            PMBO_IDX_CFG_BYTE: begin
                rd_byte = cfg_byte_reg;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // apb answer: one wait state, error on unmapped index
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'h0;
            pslverr <= 1'h0;
            prdata <= '0;
        end else if (acc_start) begin
            pready <= 1'h1;
            pslverr <= ~hit;
            prdata <= {24'h000000, rd_byte};
        end else begin
            pready <= 1'h0;
            pslverr <= 1'h0;
        end
    end

    // assertion helpers
    logic past_valid_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            past_valid_reg <= 1'h0;
        end else begin
            past_valid_reg <= 1'h1;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_cold_set_por: assert property ( // R1
        por_rise |=> cold_flag_reg)
        else $error("cold flag not set after power-on");

    a_cold_hold_warm: assert property ( // R18
        cold_flag_reg && !wr_pwr |=> cold_flag_reg)
        else $error("cold flag lost without a write");

    a_flag_on_drop: assert property ( // R3
        det_en_reg && fall_xing && !rst_sel_reg
        |=> evt_flag_reg ##1 brownout_irq_req || !brownout_irq_enable ||
            !global_irq_enable || !det_en_reg || !evt_flag_reg)
        else $error("drop did not raise flag and interrupt");

    a_reset_on_drop: assert property ( // R4
        det_en_reg && rst_sel_reg && fall_xing |=> brownout_reset_req
        ##1 !brownout_reset_req)
        else $error("drop with reset select gave no single reset pulse");

    a_flag_no_relevel: assert property ( // R5
        !evt_flag_reg && below_sync && $stable(below_sync) && !wr_ctrl_ok
        |=> !evt_flag_reg)
        else $error("flag set again without a crossing");

    a_flag_on_rise: assert property ( // R6
        det_en_reg && rise_xing |=> evt_flag_reg)
        else $error("recovery crossing did not set flag");

    a_irq_gate: assert property ( // R8
        past_valid_reg |-> brownout_irq_req == $past(evt_flag_reg &&
        det_en_reg && brownout_irq_enable && global_irq_enable))
        else $error("interrupt request does not follow its gate");

    a_cfg_load: assert property ( // R9
        warm_reset |=> det_en_reg == !$past(cfg_byte_reg[PMBO_CFG_DET_DIS])
        && thr_sel_reg == !$past(cfg_byte_reg[PMBO_CFG_THR]))
        else $error("control bits not loaded from config");

    a_disabled_quiet: assert property ( // R20
        !det_en_reg && !evt_flag_reg && !wr_ctrl_ok |=> !evt_flag_reg
        && !brownout_reset_req)
        else $error("disabled detection produced an event");

    a_ta_guard: assert property ( // R15
        wr_ctrl && ta_state_reg != TA_OPEN && !cfg_load
        |=> $stable(det_en_reg) && $stable(rst_sel_reg))
        else $error("locked control register took a write");

    a_status_read: assert property ( // R13
        acc_start && idx == PMBO_IDX_MON_CTRL
        |=> prdata[PMBO_BIT_STATUS] == !$past(below_sync))
        else $error("status bit does not reflect supply");

    c_drop_irq: cover property (
        fall_xing && det_en_reg && !rst_sel_reg ##[1:4] brownout_irq_req);
    c_drop_reset: cover property (brownout_reset_req);
    c_ta_write: cover property (wr_ctrl_ok);
    c_cold_clear: cover property (cold_flag_reg ##1 !cold_flag_reg);

endmodule : pmbo_top
`default_nettype wire

/* File: pmbo_cpu_model.sv */
// partner model: cpu reset logic and interrupt enable bits
// assumes the block's reset request is a one-cycle pulse on pclk
`timescale 1ns/1ps
`default_nettype none
module pmbo_cpu_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench commands
    input wire logic sw_warm,
    input wire logic ie_src,
    input wire logic ie_all,
    // block side
    input wire logic brownout_reset_req,
    output logic warm_reset,
    output logic brownout_irq_enable,
    output logic global_irq_enable,
    output logic [7:0] n_rst
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warm_reset <= 1'h0;
            n_rst <= 8'h00;
        end else begin
            warm_reset <= sw_warm | brownout_reset_req;
            if (brownout_reset_req) begin
                n_rst <= n_rst + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_irq_enable <= 1'h0;
            global_irq_enable <= 1'h0;
        end else begin
            brownout_irq_enable <= ie_src;
            global_irq_enable <= ie_all;
        end
    end
endmodule : pmbo_cpu_model
`default_nettype wire

/* File: test_power_monitor_brownout.sv */
// testbench of the power monitor and brown-out block
// assumes one wait state on apb and the cpu partner model beside it
`timescale 1ns/1ps
`default_nettype none
module test_power_monitor_brownout;
    import pmbo_pkg::*;
    localparam logic [11:0] A_PWR = {PMBO_IDX_PWR_CTRL, 2'h0};
    localparam logic [11:0] A_MON = {PMBO_IDX_MON_CTRL, 2'h0};
    localparam logic [11:0] A_TA = {PMBO_IDX_TA_KEY, 2'h0};
    localparam logic [11:0] A_CFG = {PMBO_IDX_CFG_BYTE, 2'h0};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic supply_below, por_level_ok, det_enable_out, thr_select_out;
    logic warm_reset, brownout_irq_enable, global_irq_enable;
    logic brownout_reset_req, brownout_irq_req, sw_warm, ie_src, ie_all;
    logic [7:0] n_rst;
    int n_fail = 0;
    int comparisons = 0;

    // block under test and its partner
    pmbo_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .supply_below(supply_below),
        .por_level_ok(por_level_ok), .det_enable_out(det_enable_out),
        .thr_select_out(thr_select_out), .warm_reset(warm_reset),
        .brownout_irq_enable(brownout_irq_enable),
        .global_irq_enable(global_irq_enable),
        .brownout_reset_req(brownout_reset_req),
        .brownout_irq_req(brownout_irq_req));
    pmbo_cpu_model cpu (.pclk(pclk), .presetn(presetn),
        .sw_warm(sw_warm), .ie_src(ie_src), .ie_all(ie_all),
        .brownout_reset_req(brownout_reset_req), .warm_reset(warm_reset),
        .brownout_irq_enable(brownout_irq_enable),
        .global_irq_enable(global_irq_enable), .n_rst(n_rst));

    task automatic results;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) n_fail++;
        v = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // unlock then write; bit 2 is 0 in every value used
    task automatic mon_wr(input logic [31:0] d);
        apb(1'h1, A_TA, 32'(PMBO_TA_KEY1));
        apb(1'h1, A_TA, 32'(PMBO_TA_KEY2));
        apb(1'h1, A_MON, d);
    endtask : mon_wr

    // warm reset pulse from the cpu side
    task automatic warm;
        @(posedge pclk);
        sw_warm <= 1'h1;
        @(posedge pclk);
        sw_warm <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask : warm

    task automatic t_reset;
        apb(1'h0, A_CFG, 32'h0);
        chk(v, 32'h0000_00FF);
        apb(1'h0, A_MON, 32'h0);
        chk(v, 32'h0000_0011);
        chk(32'(det_enable_out), 32'h0);
        chk(32'(thr_select_out), 32'h0);
        apb(1'h0, A_PWR, 32'h0);
        chk(v & 32'h10, 32'h10);
        apb(1'h0, 12'hFFC, 32'h0);
        chk({v[30:0], err}, 32'h1);
        mon_wr(32'h10);
        apb(1'h0, A_MON, 32'h0);
        chk(v, 32'h0000_0011);
    endtask : t_reset

    task automatic t_cold;
        apb(1'h1, A_PWR, 32'h0);
        apb(1'h0, A_PWR, 32'h0);
        chk(v & 32'h10, 32'h0);
        warm();
        apb(1'h0, A_PWR, 32'h0);
        chk(v & 32'h10, 32'h0);
        por_level_ok <= 1'h0;
        repeat (6) @(posedge pclk);
        por_level_ok <= 1'h1;
        repeat (6) @(posedge pclk);
        apb(1'h0, A_PWR, 32'h0);
        chk(v & 32'h10, 32'h10);
    endtask : t_cold

    task automatic t_cfg;
        apb(1'h1, A_MON, 32'h0000_00C0);
        apb(1'h0, A_MON, 32'h0);
        chk(v, 32'h0000_0011);
        apb(1'h1, A_CFG, 32'h0000_002F);
        warm();
        apb(1'h0, A_MON, 32'h0);
        chk(v, 32'h0000_00C1);
        chk(32'(det_enable_out), 32'h1);
        chk(32'(thr_select_out), 32'h1);
        mon_wr(32'h0000_0080);
        apb(1'h0, A_MON, 32'h0);
        chk(v, 32'h0000_0081);
        chk(32'(thr_select_out), 32'h0);
    endtask : t_cfg

    task automatic t_irq;
        ie_src <= 1'h1;
        supply_below <= 1'h1;
        repeat (6) @(posedge pclk);
        apb(1'h0, A_MON, 32'h0);
        chk(v, 32'h0000_0088);
        chk(32'(brownout_irq_req), 32'h0);
        ie_all <= 1'h1;
        repeat (3) @(posedge pclk);
        chk(32'(brownout_irq_req), 32'h1);
        mon_wr(32'h0000_0080);
        repeat (8) @(posedge pclk);
        apb(1'h0, A_MON, 32'h0);
        chk(v, 32'h0000_0080);
        chk(32'(brownout_irq_req), 32'h0);
        supply_below <= 1'h0;
        repeat (6) @(posedge pclk);
        apb(1'h0, A_MON, 32'h0);
        chk(v, 32'h0000_0089);
        chk(32'(n_rst), 32'h0);
        mon_wr(32'h0000_0080);
    endtask : t_irq

    task automatic t_rst;
        mon_wr(32'h0000_0090);
        supply_below <= 1'h1;
        repeat (8) @(posedge pclk);
        chk(32'(n_rst), 32'h1);
        apb(1'h0, A_MON, 32'h0);
        chk(v, 32'h0000_00C0);
        supply_below <= 1'h0;
        repeat (6) @(posedge pclk);
        apb(1'h0, A_MON, 32'h0);
        chk(v, 32'h0000_00C9);
        chk(32'(n_rst), 32'h1);
    endtask : t_rst

    task automatic t_dis;
        mon_wr(32'h0000_0000);
        // enable reaches the analog pin one edge after the register
        repeat (2) @(posedge pclk);
        chk(32'(det_enable_out), 32'h0);
        supply_below <= 1'h1;
        repeat (8) @(posedge pclk);
        apb(1'h0, A_MON, 32'h0);
        chk(v, 32'h0000_0000);
        chk(32'(brownout_irq_req), 32'h0);
        supply_below <= 1'h0;
        repeat (6) @(posedge pclk);
        apb(1'h0, A_MON, 32'h0);
        chk(v, 32'h0000_0001);
        chk(32'(n_rst), 32'h1);
    endtask : t_dis

    // free-running clock
    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        results();
    end

    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, sw_warm, ie_src, ie_all} = 7'h00;
        {supply_below, por_level_ok} = 2'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        por_level_ok <= 1'h1;
        repeat (6) @(posedge pclk);
        t_reset();
        t_cold();
        t_cfg();
        t_irq();
        t_rst();
        t_dis();
        results();
    end
endmodule : test_power_monitor_brownout
`default_nettype wire
